// File: bench/dfsr_master_model.sv
// master model issuing decoded register requests, unicast and broadcast
// assumes the bank answers own-address requests one cycle after taking them
`timescale 1ns/1ps
module dfsr_master_model
	import dfsr_pkg::*;
(
	input wire logic i_clk,
	output logic o_req_valid,
	output dfsr_pkg::dfsr_slave_t o_req_slave,
	output logic o_req_write,
	output dfsr_pkg::dfsr_addr_t o_req_reg,
	output dfsr_pkg::dfsr_word_t o_req_wdata,
	input wire logic i_resp_valid,
	input wire logic i_resp_error,
	input wire dfsr_pkg::dfsr_word_t i_resp_rdata
);
	initial begin
		o_req_valid = 1'b0;
		o_req_slave = 8'hff;
		o_req_write = 1'b0;
		o_req_reg = 16'hffff;
		o_req_wdata = 16'hffff;
	end
	// one request pulse, released lines inverted, answer sampled next edge
	task automatic xfer(input dfsr_slave_t sl, input logic w, input dfsr_addr_t a, input dfsr_word_t d,
		output logic rv, output logic re, output dfsr_word_t rd);
		@(posedge i_clk);
		o_req_valid <= 1'b1;
		o_req_slave <= sl;
		o_req_write <= w;
		o_req_reg <= a;
		o_req_wdata <= d;
		@(posedge i_clk);
		o_req_valid <= 1'b0;
		o_req_slave <= ~sl;
		o_req_write <= ~w;
		o_req_reg <= ~a;
		o_req_wdata <= ~d;
		@(posedge i_clk);
		rv = i_resp_valid;
		re = i_resp_error;
		rd = i_resp_rdata;
	endtask
endmodule

// File: bench/dfsr_regs_props.sv
// assertions on the fault status bank ports
// assumes one clock domain with an asynchronous active-low reset
`timescale 1ns/1ps
module dfsr_regs_props
	import dfsr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_req_valid,
	input wire dfsr_pkg::dfsr_slave_t i_req_slave,
	input wire logic i_req_write,
	input wire dfsr_pkg::dfsr_addr_t i_req_reg,
	input wire dfsr_pkg::dfsr_word_t i_req_wdata,
	input wire dfsr_pkg::dfsr_slave_t i_own_slave,
	input wire logic o_resp_valid,
	input wire dfsr_pkg::dfsr_word_t o_resp_rdata,
	input wire logic i_high_current_alarm,
	input wire logic i_comm_err_evt,
	input wire dfsr_pkg::dfsr_slave_t i_comm_err_cause,
	input wire logic i_fault_reset,
	input wire logic i_input_function_setting_one,
	input wire logic o_run,
	input wire logic o_reverse,
	input wire logic o_ext_fault,
	input wire logic o_fault_reset_pulse,
	input wire logic o_digital_input_five,
	input wire logic o_digital_input_six,
	input wire logic o_digital_input_seven,
	input wire dfsr_pkg::dfsr_slave_t o_comm_err_cause
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_own_read;
		i_req_valid && !i_req_write && i_req_slave == i_own_slave && i_own_slave != BROADCAST_SLAVE_ADDR;
	endsequence
	sequence s_bcast_cmd;
		i_req_valid && i_req_write && i_req_slave == BROADCAST_SLAVE_ADDR && i_req_reg == OFS_BROADCAST_RUN_COMMAND_WORD;
	endsequence
	chk_bcast_silent: assert property (i_req_valid && i_req_slave == BROADCAST_SLAVE_ADDR |=> !o_resp_valid)
		else $error("broadcast request was answered");
	chk_run_dir: assert property (s_bcast_cmd |=> {o_reverse, o_run} == $past(i_req_wdata[1:0]))
		else $error("run or direction does not follow broadcast word");
	chk_inputs_five_seven: assert property (s_bcast_cmd |=>
		{o_digital_input_seven, o_digital_input_six, o_digital_input_five} == $past(i_req_wdata[14:12]))
		else $error("digital inputs five to seven do not follow broadcast word");
	chk_ext_enable: assert property (o_ext_fault |-> i_input_function_setting_one)
		else $error("external fault without its input setting");
	chk_alarm_read: assert property (s_own_read ##0 (i_req_reg == OFS_ALARM_SUMMARY_FIVE &&
		$stable(i_high_current_alarm) && $past(i_rst_n)) |=> (o_resp_rdata & 16'hc007) == 16'h0000 &&
		o_resp_rdata[AL5_HIGH_CURRENT] == $past(i_high_current_alarm))
		else $error("alarm summary read wrong");
	chk_opt_reserved: assert property (s_own_read ##0 i_req_reg == OFS_OPTION_CARD_FAULT_SUMMARY |=>
		(o_resp_rdata & 16'hffe4) == 16'h0000)
		else $error("option fault reserved bits set");
	chk_cause_load: assert property (i_comm_err_evt |=> o_comm_err_cause == $past(i_comm_err_cause))
		else $error("error cause not loaded");
	chk_cause_hold: assert property (!i_comm_err_evt && !i_fault_reset && !o_fault_reset_pulse |=>
		$stable(o_comm_err_cause))
		else $error("error cause changed without fault reset");
endmodule
bind dfsr_regs dfsr_regs_props dfsr_regs_props_i (.*);

// File: bench/tb_dfsr_regs.sv
// self-checking bench for the fault status bank and broadcast command word
// assumes the master model drives requests and the bench drives all conditions
`timescale 1ns/1ps
module tb_dfsr_regs;
	import dfsr_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic rv, re, r_valid, r_error, q_valid, q_write, run, rev, extf, frp, d5, d6, d7;
	logic frst = 1'b0, evt = 1'b0, coarse = 1'b0, set1 = 1'b1, set2 = 1'b1;
	logic [6:0] al = 7'h00;
	logic [19:0] cur = 20'h00000;
	dfsr_slave_t q_slave, cc, cause = 8'h00;
	dfsr_addr_t q_reg;
	dfsr_word_t q_wdata, r_rdata, rd, spd, cf1 = 16'h0000, cf2 = 16'h0000, opt = 16'h0000;
	int bad_count = 0;
	int check_count = 0;
	int frp_count = 0;
	always #20 i_clk = ~i_clk;
	// counts cycles in which the fault reset pulse stands
	always @(posedge i_clk) begin
		if (frp === 1'b1) begin
			frp_count++;
		end
	end
	dfsr_master_model dfsr_master_model_i (.i_clk(i_clk), .o_req_valid(q_valid), .o_req_slave(q_slave),
		.o_req_write(q_write), .o_req_reg(q_reg), .o_req_wdata(q_wdata), .i_resp_valid(r_valid),
		.i_resp_error(r_error), .i_resp_rdata(r_rdata));
	dfsr_regs dfsr_regs_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_valid(q_valid), .i_req_slave(q_slave),
		.i_req_write(q_write), .i_req_reg(q_reg), .i_req_wdata(q_wdata), .i_own_slave(8'h11),
		.o_resp_valid(r_valid), .o_resp_error(r_error), .o_resp_rdata(r_rdata),
		.i_high_current_alarm(al[0]), .i_ext_fault_input_one(al[1]), .i_ext_fault_input_two(al[2]),
		.i_safe_disable_fault(al[3]), .i_safe_disable_active(al[4]), .i_mech_weakening_one(al[5]),
		.i_mech_weakening_two(al[6]), .i_ctrl_fault_one(cf1), .i_ctrl_fault_two(cf2), .i_option_fault(opt),
		.i_comm_err_evt(evt), .i_comm_err_cause(cause), .i_fault_reset(frst), .i_current_centi_amp(cur),
		.i_rating_coarse(coarse), .i_input_function_setting_one(set1), .i_input_function_setting_two(set2),
		.o_run(run), .o_reverse(rev), .o_ext_fault(extf), .o_fault_reset_pulse(frp),
		.o_digital_input_five(d5), .o_digital_input_six(d6), .o_digital_input_seven(d7),
		.o_speed_reference(spd), .o_comm_err_cause(cc));
	task automatic results();
		if (bad_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input string n, input dfsr_word_t s, input dfsr_word_t e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic xf(input dfsr_slave_t sl, input logic w, input dfsr_addr_t a, input dfsr_word_t d);
		dfsr_master_model_i.xfer(sl, w, a, d, rv, re, rd);
	endtask
	task automatic rd_chk(input string n, input dfsr_addr_t a, input dfsr_word_t e);
		xf(8'h11, 1'b0, a, 16'h0000);
		check({n, " answer"}, {14'h0, rv, re}, 16'h0002);
		check(n, rd, e);
	endtask
	task automatic pulse_frst();
		@(posedge i_clk);
		frst <= 1'b1;
		@(posedge i_clk);
		frst <= 1'b0;
	endtask
	task automatic t_alarm();
		int pos[7] = '{3, 8, 9, 10, 11, 12, 13};
		for (int k = 0; k < 7; k++) begin
			@(posedge i_clk);
			al <= 7'h01 << k;
			rd_chk("alarm five", OFS_ALARM_SUMMARY_FIVE, 16'h0001 << pos[k]);
		end
		@(posedge i_clk);
		al <= 7'h00;
		rd_chk("alarm five clear", OFS_ALARM_SUMMARY_FIVE, 16'h0000);
	endtask
	task automatic t_fault();
		dfsr_addr_t rg[3] = '{OFS_CONTROL_FAULT_SUMMARY_ONE, OFS_CONTROL_FAULT_SUMMARY_TWO, OFS_OPTION_CARD_FAULT_SUMMARY};
		dfsr_word_t mk[3] = '{16'h79cc, 16'h01ff, 16'h001b};
		for (int k = 0; k < 3; k++) begin
			@(posedge i_clk);
			{cf1, cf2, opt} <= 48'hffff_0000_0000 >> (16 * k);
			@(posedge i_clk);
			{cf1, cf2, opt} <= 48'h0;
			rd_chk("fault held", rg[k], mk[k]);
			pulse_frst();
			rd_chk("fault cleared", rg[k], 16'h0000);
		end
	endtask
	task automatic t_current();
		logic [19:0] c[4] = '{20'd12345, 20'd12345, 20'hfffff, 20'h1869f};
		dfsr_word_t e[4] = '{16'h3039, 16'h04d2, 16'hffff, 16'h270f};
		for (int k = 0; k < 4; k++) begin
			@(posedge i_clk);
			cur <= c[k];
			coarse <= k[0];
			rd_chk("current", OFS_OUTPUT_CURRENT_READING, e[k]);
		end
	endtask
	task automatic t_comm();
		int f0;
		@(posedge i_clk);
		evt <= 1'b1;
		cause <= 8'h5a;
		@(posedge i_clk);
		evt <= 1'b0;
		cause <= 8'ha5;
		repeat (3) @(posedge i_clk);
		check("cause held", cc, 16'h005a);
		f0 = frp_count;
		pulse_frst();
		repeat (2) @(posedge i_clk);
		check("cause cleared", cc, 16'h0000);
		check("fault reset pass", 16'(frp_count - f0), 16'h0001);
	endtask
	task automatic t_bcast();
		int f0;
		@(posedge i_clk);
		cf2 <= 16'h0001;
		@(posedge i_clk);
		cf2 <= 16'h0000;
		f0 = frp_count;
		xf(BROADCAST_SLAVE_ADDR, 1'b1, OFS_BROADCAST_RUN_COMMAND_WORD, 16'hffff);
		check("bcast answer", {15'h0, rv}, 16'h0000);
		check("run dir", {14'h0, rev, run}, 16'h0003);
		check("ext fault", {15'h0, extf}, 16'h0001);
		check("inputs", {13'h0, d7, d6, d5}, 16'h0007);
		rd_chk("cmd word", OFS_BROADCAST_RUN_COMMAND_WORD, 16'h7033);
		check("cmd reset pulse", 16'(frp_count - f0), 16'h0001);
		rd_chk("cmd reset clears", OFS_CONTROL_FAULT_SUMMARY_TWO, 16'h0000);
		set1 <= 1'b0;
		@(posedge i_clk);
		check("ext gated", {15'h0, extf}, 16'h0000);
		xf(BROADCAST_SLAVE_ADDR, 1'b1, OFS_BROADCAST_RUN_COMMAND_WORD, 16'h0002);
		check("reverse stop", {14'h0, rev, run}, 16'h0002);
		set2 <= 1'b0;
		f0 = frp_count;
		xf(BROADCAST_SLAVE_ADDR, 1'b1, OFS_BROADCAST_RUN_COMMAND_WORD, 16'h0020);
		@(posedge i_clk);
		check("reset gated", 16'(frp_count - f0), 16'h0000);
		xf(BROADCAST_SLAVE_ADDR, 1'b1, OFS_BROADCAST_SPEED_REFERENCE, 16'h2a5c);
		check("speed ref", spd, 16'h2a5c);
		xf(8'h33, 1'b1, OFS_BROADCAST_RUN_COMMAND_WORD, 16'h0001);
		check("other slave", {14'h0, rv, run}, 16'h0000);
		xf(8'h11, 1'b1, OFS_ALARM_SUMMARY_FIVE, 16'hffff);
		check("ro write", {14'h0, rv, re}, 16'h0003);
		xf(8'h11, 1'b0, 16'h0003, 16'h0000);
		check("unmapped", {14'h0, rv, re}, 16'h0003);
	endtask
	initial begin
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_alarm();
		t_fault();
		t_current();
		t_comm();
		t_bcast();
		results();
	end
	initial begin
		#100000;
		bad_count++;
		results();
	end
endmodule

// File: core/dfsr_current_scale.sv
// output current reading in register units from a 0.01 A sample
// assumes i_current_centi_amp is a steady sample in 0.01 A counts
`timescale 1ns/1ps
module dfsr_current_scale
	import dfsr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [dfsr_pkg::CUR_IN_W-1:0] i_current_centi_amp,
	input wire logic i_rating_coarse,
	output dfsr_pkg::dfsr_word_t o_reading
);
	// ----------------------------------------
	// scaling and saturation
	// ----------------------------------------
	localparam logic [CUR_IN_W-1:0] DIV = CUR_IN_W'(CUR_COARSE_DIV);
	localparam logic [CUR_IN_W-1:0] WORD_MAX = CUR_IN_W'(16'hffff);

	logic [CUR_IN_W-1:0] scaled;
	dfsr_word_t reading_q;

	always_comb begin
		scaled = i_current_centi_amp;
		if (i_rating_coarse) begin
			scaled = i_current_centi_amp / DIV; // 0.1 A per count
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			reading_q <= STATUS_RESET;
		end else if (scaled > WORD_MAX) begin
			reading_q <= 16'hffff;
		end else begin
			reading_q <= scaled[DFSR_DW-1:0]; // 0.01 A per count below 15 kW
		end
	end

	assign o_reading = reading_q;
endmodule

// File: core/dfsr_fault_latch.sv
// sticky fault bits, set by condition pulses or levels, cleared by fault reset
// assumes set and clear are synchronous to i_clk
`timescale 1ns/1ps
module dfsr_fault_latch #(
	parameter int W = 16,
	parameter logic [W-1:0] MASK = '1
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_set,
	input wire logic i_clear,
	output logic [W-1:0] o_bits
);
	// ----------------------------------------
	// latch
	// ----------------------------------------
	logic [W-1:0] bits_q;
	logic [W-1:0] bits_d;

	always_comb begin
		bits_d = bits_q;
		if (i_clear) begin
			bits_d = '0;
		end
		bits_d = (bits_d | i_set) & MASK; // set wins over clear
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bits_q <= '0;
		end else begin
			bits_q <= bits_d;
		end
	end

	assign o_bits = bits_q;
endmodule

// File: core/dfsr_regs.sv
// drive fault status register bank with broadcast command word
// assumes link framing is decoded elsewhere into one-cycle register requests
`timescale 1ns/1ps

// Behaviour
// - alarm summary five bit 3 shows high current alarm while present
// - alarm five bits 8 and 9 show external faults of inputs one and two
// - alarm five bits A and B show safe-disable fault and active states
// - alarm five bits C, D show mechanical weakening one, two; E, F reserved
// - control fault one bits 2,3,6,7,8 show converter, modulation, board, link, nvm faults
// - control fault one bits B to E show memory, flash, watchdog, circuit faults
// - control fault two bits 0 to 8 show nine hardware faults; rest reserved
// - option fault bits 0,1,3,4 show option faults; bits 5 to F reserved
// - current reads 0.01 A per count, or 0.1 A at 15 kW and above
// - communication error cause held until fault reset
// - a broadcast write is applied by every slave
// - broadcast messages are acted on but never answered
// - command bit 0 run or stop, bit 1 reverse or forward
// - command bit 4 external fault, bit 5 fault reset, per input settings
// - command bits C, D, E drive digital inputs five to seven
module dfsr_regs
	import dfsr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	// register request from the link
	input wire logic i_req_valid,
	input wire dfsr_pkg::dfsr_slave_t i_req_slave,
	input wire logic i_req_write,
	input wire dfsr_pkg::dfsr_addr_t i_req_reg,
	input wire dfsr_pkg::dfsr_word_t i_req_wdata,
	input wire dfsr_pkg::dfsr_slave_t i_own_slave,
	// response to the link
	output logic o_resp_valid,
	output logic o_resp_error,
	output dfsr_pkg::dfsr_word_t o_resp_rdata,
	// alarm conditions, levels
	input wire logic i_high_current_alarm,
	input wire logic i_ext_fault_input_one,
	input wire logic i_ext_fault_input_two,
	input wire logic i_safe_disable_fault,
	input wire logic i_safe_disable_active,
	input wire logic i_mech_weakening_one,
	input wire logic i_mech_weakening_two,
	// fault conditions, bit vectors in register layout
	input wire dfsr_pkg::dfsr_word_t i_ctrl_fault_one,
	input wire dfsr_pkg::dfsr_word_t i_ctrl_fault_two,
	input wire dfsr_pkg::dfsr_word_t i_option_fault,
	// communication error event
	input wire logic i_comm_err_evt,
	input wire dfsr_pkg::dfsr_slave_t i_comm_err_cause,
	input wire logic i_fault_reset,
	// output current
	input wire logic [dfsr_pkg::CUR_IN_W-1:0] i_current_centi_amp,
	input wire logic i_rating_coarse,
	// input function settings for command bits 4 and 5
	input wire logic i_input_function_setting_one,
	input wire logic i_input_function_setting_two,
	// command outputs
	output logic o_run,
	output logic o_reverse,
	output logic o_ext_fault,
	output logic o_fault_reset_pulse,
	output logic o_digital_input_five,
	output logic o_digital_input_six,
	output logic o_digital_input_seven,
	output dfsr_pkg::dfsr_word_t o_speed_reference,
	output dfsr_pkg::dfsr_slave_t o_comm_err_cause
);
	// ----------------------------------------
	// request decode
	// ----------------------------------------
	logic is_bcast;
	logic is_own;
	logic wr_cmd;
	logic wr_speed;

	always_comb begin
		is_bcast = i_req_valid && (i_req_slave == BROADCAST_SLAVE_ADDR);
		is_own = i_req_valid && !is_bcast && (i_req_slave == i_own_slave);
		wr_cmd = (is_bcast || is_own) && i_req_write && (i_req_reg == OFS_BROADCAST_RUN_COMMAND_WORD);
		wr_speed = (is_bcast || is_own) && i_req_write && (i_req_reg == OFS_BROADCAST_SPEED_REFERENCE);
	end

	// ----------------------------------------
	// command word and speed reference
	// ----------------------------------------
	dfsr_word_t cmd_q;
	dfsr_word_t speed_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmd_q <= CMD_RESET;
		end else if (wr_cmd) begin
			cmd_q <= i_req_wdata & CMD_MASK; // reserved bits dropped
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			speed_q <= SPEED_REF_RESET;
		end else if (wr_speed) begin
			speed_q <= i_req_wdata;
		end
	end

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	logic reset_bit_q;
	logic fault_reset;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			reset_bit_q <= 1'b0;
		end else begin
			reset_bit_q <= cmd_q[CMD_FAULT_RESET];
		end
	end

	always_comb begin
		fault_reset = i_fault_reset;
		if (i_input_function_setting_two && cmd_q[CMD_FAULT_RESET] && !reset_bit_q) begin
			fault_reset = 1'b1; // rising edge of command bit 5
		end
	end

	assign o_run = cmd_q[CMD_RUN];
	assign o_reverse = cmd_q[CMD_REVERSE];
	assign o_ext_fault = cmd_q[CMD_EXT_FAULT] & i_input_function_setting_one;
	assign o_fault_reset_pulse = fault_reset;
	assign o_digital_input_five = cmd_q[CMD_DIGITAL_INPUT_FIVE];
	assign o_digital_input_six = cmd_q[CMD_DIGITAL_INPUT_SIX];
	assign o_digital_input_seven = cmd_q[CMD_DIGITAL_INPUT_SEVEN];
	assign o_speed_reference = speed_q;

	// ----------------------------------------
	// alarm summary, follows conditions
	// ----------------------------------------
	dfsr_word_t alarm_q;
	dfsr_word_t alarm_d;

	always_comb begin
		alarm_d = STATUS_RESET;
		alarm_d[AL5_HIGH_CURRENT] = i_high_current_alarm;
		alarm_d[AL5_EXT_FAULT_ONE] = i_ext_fault_input_one;
		alarm_d[AL5_EXT_FAULT_TWO] = i_ext_fault_input_two;
		alarm_d[AL5_SAFE_DISABLE_FAULT] = i_safe_disable_fault;
		alarm_d[AL5_SAFE_DISABLE_ACTIVE] = i_safe_disable_active;
		alarm_d[AL5_MECH_WEAK_ONE] = i_mech_weakening_one;
		alarm_d[AL5_MECH_WEAK_TWO] = i_mech_weakening_two;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			alarm_q <= STATUS_RESET;
		end else begin
			alarm_q <= alarm_d; // clears when condition ends
		end
	end

	// ----------------------------------------
	// sticky fault summaries
	// ----------------------------------------
	dfsr_word_t cf1;
	dfsr_word_t cf2;
	dfsr_word_t opt;

	dfsr_fault_latch #(.W(DFSR_DW), .MASK(CF1_MASK)) u_cf1 (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_set(i_ctrl_fault_one),
		.i_clear(fault_reset),
		.o_bits(cf1)
	);

	dfsr_fault_latch #(.W(DFSR_DW), .MASK(CF2_MASK)) u_cf2 (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_set(i_ctrl_fault_two),
		.i_clear(fault_reset),
		.o_bits(cf2)
	);

	dfsr_fault_latch #(.W(DFSR_DW), .MASK(OPT_MASK)) u_opt (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_set(i_option_fault),
		.i_clear(fault_reset),
		.o_bits(opt)
	);

	// ----------------------------------------
	// communication error cause
	// ----------------------------------------
	dfsr_slave_t comm_err_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			comm_err_q <= COMM_ERR_RESET;
		end else if (i_comm_err_evt) begin
			comm_err_q <= i_comm_err_cause; // new event wins over reset
		end else if (fault_reset) begin
			comm_err_q <= COMM_ERR_RESET; // held until fault reset
		end
	end

	assign o_comm_err_cause = comm_err_q;

	// ----------------------------------------
	// output current
	// ----------------------------------------
	dfsr_word_t current;

	dfsr_current_scale u_cur (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_current_centi_amp(i_current_centi_amp),
		.i_rating_coarse(i_rating_coarse),
		.o_reading(current)
	);

	// ----------------------------------------
	// read mux and response
	// ----------------------------------------
	dfsr_word_t rdata;
	logic err;

	always_comb begin
		rdata = STATUS_RESET;
		err = 1'b0;
		unique case (i_req_reg)
			OFS_BROADCAST_RUN_COMMAND_WORD: rdata = cmd_q;
			OFS_BROADCAST_SPEED_REFERENCE: rdata = speed_q;
			OFS_ALARM_SUMMARY_FIVE: begin
				rdata = alarm_q;
				err = i_req_write;
			end
			OFS_CONTROL_FAULT_SUMMARY_ONE: begin
				rdata = cf1;
				err = i_req_write;
			end
			OFS_CONTROL_FAULT_SUMMARY_TWO: begin
				rdata = cf2;
				err = i_req_write;
			end
			OFS_OPTION_CARD_FAULT_SUMMARY: begin
				rdata = opt;
				err = i_req_write;
			end
			OFS_OUTPUT_CURRENT_READING: begin
				rdata = current;
				err = i_req_write;
			end
			default: err = 1'b1;
		endcase
	end

	logic resp_valid_q;
	logic resp_error_q;
	dfsr_word_t resp_rdata_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			resp_valid_q <= 1'b0;
			resp_error_q <= 1'b0;
			resp_rdata_q <= STATUS_RESET;
		end else begin
			resp_valid_q <= is_own; // no answer to broadcast
			if (is_own) begin
				resp_error_q <= err;
				resp_rdata_q <= (err || i_req_write) ? STATUS_RESET : rdata;
			end
		end
	end

	assign o_resp_valid = resp_valid_q;
	assign o_resp_error = resp_error_q;
	assign o_resp_rdata = resp_rdata_q;
endmodule

// File: pkg/dfsr_pkg.sv
// drive fault status register bank: offsets, field positions, masks, reset values
// assumes 16-bit register words addressed by 16-bit register numbers
package dfsr_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int DFSR_DW = 16;
	localparam int DFSR_AW = 16;
	localparam int DFSR_SW = 8;

	typedef logic [DFSR_DW-1:0] dfsr_word_t;
	typedef logic [DFSR_AW-1:0] dfsr_addr_t;
	typedef logic [DFSR_SW-1:0] dfsr_slave_t;

	// ----------------------------------------
	// register numbers
	// ----------------------------------------
	localparam dfsr_addr_t OFS_BROADCAST_RUN_COMMAND_WORD = 16'h0001;
	localparam dfsr_addr_t OFS_BROADCAST_SPEED_REFERENCE = 16'h0002;
	localparam dfsr_addr_t OFS_ALARM_SUMMARY_FIVE = 16'h00cb;
	localparam dfsr_addr_t OFS_CONTROL_FAULT_SUMMARY_ONE = 16'h00d0;
	localparam dfsr_addr_t OFS_CONTROL_FAULT_SUMMARY_TWO = 16'h00d1;
	localparam dfsr_addr_t OFS_OPTION_CARD_FAULT_SUMMARY = 16'h00d8;
	localparam dfsr_addr_t OFS_OUTPUT_CURRENT_READING = 16'h00fb;

	localparam dfsr_slave_t BROADCAST_SLAVE_ADDR = 8'h00;

	// ----------------------------------------
	// alarm summary five fields
	// ----------------------------------------
	localparam int AL5_HIGH_CURRENT = 3;
	localparam int AL5_EXT_FAULT_ONE = 8;
	localparam int AL5_EXT_FAULT_TWO = 9;
	localparam int AL5_SAFE_DISABLE_FAULT = 10;
	localparam int AL5_SAFE_DISABLE_ACTIVE = 11;
	localparam int AL5_MECH_WEAK_ONE = 12;
	localparam int AL5_MECH_WEAK_TWO = 13;

	// ----------------------------------------
	// implemented-bit masks, reserved bits zero
	// ----------------------------------------
	localparam dfsr_word_t CF1_MASK = 16'h79cc;
	localparam dfsr_word_t CF2_MASK = 16'h01ff;
	localparam dfsr_word_t OPT_MASK = 16'h001b;
	localparam dfsr_word_t CMD_MASK = 16'h7033;

	// ----------------------------------------
	// command word fields
	// ----------------------------------------
	localparam int CMD_RUN = 0;
	localparam int CMD_REVERSE = 1;
	localparam int CMD_EXT_FAULT = 4;
	localparam int CMD_FAULT_RESET = 5;
	localparam int CMD_DIGITAL_INPUT_FIVE = 12;
	localparam int CMD_DIGITAL_INPUT_SIX = 13;
	localparam int CMD_DIGITAL_INPUT_SEVEN = 14;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam dfsr_word_t CMD_RESET = 16'h0000;
	localparam dfsr_word_t SPEED_REF_RESET = 16'h0000;
	localparam dfsr_word_t STATUS_RESET = 16'h0000;
	localparam dfsr_slave_t COMM_ERR_RESET = 8'h00;

	// ----------------------------------------
	// current scaling
	// ----------------------------------------
	localparam int CUR_IN_W = 20;
	localparam int CUR_COARSE_DIV = 10;

endpackage
